// >>> inc/fccd_defines.vh
// Purpose: constants for the flash configuration command decoder
// Assumes: 64-byte reports delivered one byte per strobe, index 0 first
// Notes:   definitions only
`ifndef FCCD_DEFINES_VH
`define FCCD_DEFINES_VH
`define FCCD_CMD_WRITE_FLASH   8'hb1
`define FCCD_SUB_CHIP          8'h00
`define FCCD_SUB_PINS          8'h01
`define FCCD_SUB_STR_FIRST     8'h02
`define FCCD_SUB_STR_LAST      8'h04
`define FCCD_RESP_OK           8'h00
`define FCCD_RESP_UNSUPPORTED  8'h01
`define FCCD_REPORT_LAST       6'h3f
`define FCCD_IDX_CMD           6'h00
`define FCCD_IDX_SUB           6'h01
`define FCCD_IDX_PIN0          6'h02
`define FCCD_IDX_PIN1          6'h03
`define FCCD_IDX_PIN2          6'h04
`define FCCD_IDX_INTCFG        6'h05
`define FCCD_IDX_VID_LO        6'h06
`define FCCD_IDX_VID_HI        6'h07
`define FCCD_IDX_PID_LO        6'h08
`define FCCD_IDX_PID_HI        6'h09
`define FCCD_IDX_POWER         6'h0a
`define FCCD_IDX_CURRENT       6'h0b
`define FCCD_IDX_PWD_FIRST     6'h0c
`define FCCD_IDX_PWD_LAST      6'h13
`define FCCD_BIT_NEG_EDGE      6
`define FCCD_BIT_POS_EDGE      5
`define FCCD_BIT_REF_HI        4
`define FCCD_BIT_REF_LO        3
`define FCCD_BIT_REF_SRC       2
`define FCCD_BIT_PIN_LEVEL     4
`define FCCD_BIT_PIN_DIR       3
`define FCCD_FUNC_GPIO         3'h0
`define FCCD_P0_MAX_CODE       3'h2
`define FCCD_P1_MAX_CODE       3'h4
`define FCCD_P2_MAX_CODE       3'h3
`define FCCD_RST_PIN_CFG       5'h08
`define FCCD_RST_INTCFG        8'h00
`define FCCD_RST_WORD16        16'h0000
`define FCCD_RST_BYTE          8'h00
`endif

// >>> rtl/fccd_edge_detect.v
// Purpose: interrupt-detection input edge detector with sticky flag
// Assumes: input already synchronous to i_clk_sys
// Notes:   set wins over a same-cycle clear
`timescale 1ns/1ns
module fccd_edge_detect
(
   input  wire i_clk_sys,
   input  wire i_rst,
   input  wire i_ce,
   input  wire i_pin,
   input  wire i_neg_en,
   input  wire i_pos_en,
   input  wire i_clear,
   output reg  o_flag
);
   reg  prev_reg;
   wire fall;
   wire rise;

   assign fall = prev_reg & ~i_pin;
   assign rise = ~prev_reg & i_pin;

   // sticky flag; the event is kept if it lands on the clear cycle
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         prev_reg <= 1'b0;
         o_flag   <= 1'b0;
      end
      else if (i_ce)
      begin
         prev_reg <= i_pin;
         if ((i_neg_en & fall) | (i_pos_en & rise))
            o_flag <= 1'b1;
         else if (i_clear)
            o_flag <= 1'b0;
      end
   end
endmodule // fccd_edge_detect

// >>> rtl/fccd_decoder.v
// Purpose: decode write-flash chip-settings and pin-settings reports
// Assumes: report bytes arrive on i_byte_valid, index 0 first, 64 per report
// Notes:   staged values are committed at report end; edge enables act at once, pins and reference after reset
`timescale 1ns/1ns
`include "fccd_defines.vh"

// Notes on behaviour
// - falling edge sets flag when enabled
// - rising edge sets flag when enabled
// - two bits pick internal reference level
// - one bit picks internal reference or supply
// - vendor id from bytes six, seven
// - product id from bytes eight, nine
// - power attributes byte stored unchanged
// - current byte stored, times two milliamps
// - bytes twelve to nineteen form password
// - command b1 sub 01 means pin write
// - bit four is power-up output level
// - bit three is direction, one input
// - pin zero function codes, high ignored
// - pin one function codes, high ignored
// - pin two function codes, high ignored
// - unknown sub-code answers unsupported
module fccd_decoder
(
   input  wire        i_clk_sys,
   input  wire        i_rst,
   input  wire        i_ce,
   input  wire        i_byte_valid,
   input  wire [7:0]  i_byte,
   input  wire        i_int_pin,
   input  wire        i_int_clear,
   output reg         o_int_flag,
   output reg         o_resp_valid,
   output reg  [7:0]  o_resp_code,
   output reg         o_commit,
   output reg  [7:0]  o_nv_intcfg,
   output reg  [15:0] o_nv_vid,
   output reg  [15:0] o_nv_pid,
   output reg  [7:0]  o_nv_power,
   output reg  [7:0]  o_nv_current,
   output reg  [63:0] o_nv_password,
   output reg  [14:0] o_nv_pins,
   output reg  [1:0]  o_adc_ref_level,
   output reg         o_adc_ref_internal,
   output reg  [2:0]  o_pin_func,
   output reg  [2:0]  o_pin_dir_in,
   output reg  [2:0]  o_pin_level
);
   reg  [5:0]  idx_reg;
   reg         is_wf_reg;
   reg  [7:0]  sub_reg;
   reg  [7:0]  st_intcfg_reg;
   reg  [15:0] st_vid_reg;
   reg  [15:0] st_pid_reg;
   reg  [7:0]  st_power_reg;
   reg  [7:0]  st_current_reg;
   reg  [63:0] st_pwd_reg;
   reg  [14:0] st_pins_reg;
   reg  [14:0] live_pins_reg;
   reg         applied_reg;
   wire        last_byte;
   wire        edge_flag;
   integer     k;
   integer     j;

   // keep function code only when defined for that pin, else hold old code
   function [4:0] fccd_pin_merge;
      input [7:0] new_b;
      input [4:0] old_b;
      input [2:0] max_code;
      begin
         if (new_b[2:0] <= max_code)
            fccd_pin_merge = new_b[4:0];
         else
            fccd_pin_merge = {new_b[4:3], old_b[2:0]};
      end
   endfunction

   assign last_byte = i_byte_valid && (idx_reg == `FCCD_REPORT_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // report capture: index counter, header and staging
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         idx_reg        <= 6'h00;
         is_wf_reg      <= 1'b0;
         sub_reg        <= `FCCD_RST_BYTE;
         st_intcfg_reg  <= `FCCD_RST_INTCFG;
         st_vid_reg     <= `FCCD_RST_WORD16;
         st_pid_reg     <= `FCCD_RST_WORD16;
         st_power_reg   <= `FCCD_RST_BYTE;
         st_current_reg <= `FCCD_RST_BYTE;
         st_pwd_reg     <= 64'h0000000000000000;
         st_pins_reg    <= {3{`FCCD_RST_PIN_CFG}};
      end
      else if (i_ce && i_byte_valid)
      begin
         idx_reg <= idx_reg + 6'h01; // wraps to zero after byte 63
         if (idx_reg == `FCCD_IDX_CMD)
            is_wf_reg <= (i_byte == `FCCD_CMD_WRITE_FLASH);
         if (idx_reg == `FCCD_IDX_SUB)
            sub_reg <= i_byte;
         if (idx_reg == `FCCD_IDX_PIN0)
            st_pins_reg[4:0] <= fccd_pin_merge(i_byte, o_nv_pins[4:0], `FCCD_P0_MAX_CODE);
         if (idx_reg == `FCCD_IDX_PIN1)
            st_pins_reg[9:5] <= fccd_pin_merge(i_byte, o_nv_pins[9:5], `FCCD_P1_MAX_CODE);
         if (idx_reg == `FCCD_IDX_PIN2)
            st_pins_reg[14:10] <= fccd_pin_merge(i_byte, o_nv_pins[14:10], `FCCD_P2_MAX_CODE);
         // bits 7, 1 and 0 are dropped
         if (idx_reg == `FCCD_IDX_INTCFG)
            st_intcfg_reg <= {1'b0, i_byte[6:2], 2'b00};
         if (idx_reg == `FCCD_IDX_VID_LO)
            st_vid_reg[7:0] <= i_byte;
         if (idx_reg == `FCCD_IDX_VID_HI)
            st_vid_reg[15:8] <= i_byte;
         if (idx_reg == `FCCD_IDX_PID_LO)
            st_pid_reg[7:0] <= i_byte;
         if (idx_reg == `FCCD_IDX_PID_HI)
            st_pid_reg[15:8] <= i_byte;
         if (idx_reg == `FCCD_IDX_POWER)
            st_power_reg <= i_byte;
         if (idx_reg == `FCCD_IDX_CURRENT)
            st_current_reg <= i_byte;
         // password byte n lands in bits 8n+7..8n, first byte lowest
         for (k = 0; k < 8; k = k + 1)
            if (idx_reg == `FCCD_IDX_PWD_FIRST + k[5:0])
               st_pwd_reg[k*8 +: 8] <= i_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // commit at report end; nonvolatile image and response
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_resp_valid  <= 1'b0;
         o_resp_code   <= `FCCD_RESP_OK;
         o_commit      <= 1'b0;
         o_nv_intcfg   <= `FCCD_RST_INTCFG;
         o_nv_vid      <= `FCCD_RST_WORD16;
         o_nv_pid      <= `FCCD_RST_WORD16;
         o_nv_power    <= `FCCD_RST_BYTE;
         o_nv_current  <= `FCCD_RST_BYTE;
         o_nv_password <= 64'h0000000000000000;
         o_nv_pins     <= {3{`FCCD_RST_PIN_CFG}};
      end
      else if (i_ce)
      begin
         o_resp_valid <= 1'b0;
         o_commit     <= 1'b0;
         if (last_byte && is_wf_reg)
         begin
            o_resp_valid <= 1'b1;
            o_resp_code  <= `FCCD_RESP_OK;
            if (sub_reg == `FCCD_SUB_CHIP)
            begin
               o_commit      <= 1'b1;
               o_nv_intcfg   <= st_intcfg_reg;
               o_nv_vid      <= st_vid_reg;
               o_nv_pid      <= st_pid_reg;
               o_nv_power    <= st_power_reg;
               o_nv_current  <= st_current_reg;
               o_nv_password <= st_pwd_reg;
            end
            else if (sub_reg == `FCCD_SUB_PINS)
            begin
               o_commit  <= 1'b1;
               o_nv_pins <= st_pins_reg;
            end
            else if (sub_reg < `FCCD_SUB_STR_FIRST || sub_reg > `FCCD_SUB_STR_LAST)
               o_resp_code <= `FCCD_RESP_UNSUPPORTED;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // live settings: copied from the stored image once after reset only,
   // so a commit never disturbs running pins until the next reset
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         applied_reg        <= 1'b0;
         live_pins_reg      <= {3{`FCCD_RST_PIN_CFG}};
         o_adc_ref_level    <= 2'b00;
         o_adc_ref_internal <= 1'b0;
         o_pin_func         <= 3'h0;
         o_pin_dir_in       <= 3'h7;
         o_pin_level        <= 3'h0;
         o_int_flag         <= 1'b0;
      end
      else if (i_ce)
      begin
         o_int_flag <= edge_flag;
         if (!applied_reg)
         begin
            applied_reg        <= 1'b1;
            live_pins_reg      <= o_nv_pins;
            o_adc_ref_level    <= o_nv_intcfg[`FCCD_BIT_REF_HI:`FCCD_BIT_REF_LO];
            o_adc_ref_internal <= o_nv_intcfg[`FCCD_BIT_REF_SRC];
         end
         // per pin: gpio flag, direction, power-up drive level
         for (j = 0; j < 3; j = j + 1)
         begin
            o_pin_func[j]   <= (live_pins_reg[j*5 +: 3] == `FCCD_FUNC_GPIO);
            o_pin_dir_in[j] <= live_pins_reg[j*5 + `FCCD_BIT_PIN_DIR];
            o_pin_level[j]  <= live_pins_reg[j*5 + `FCCD_BIT_PIN_LEVEL];
         end
      end
   end

   fccd_edge_detect u_edge
   (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_pin     (i_int_pin),
      .i_neg_en  (o_nv_intcfg[`FCCD_BIT_NEG_EDGE]),
      .i_pos_en  (o_nv_intcfg[`FCCD_BIT_POS_EDGE]),
      .i_clear   (i_int_clear),
      .o_flag    (edge_flag)
   );
endmodule // fccd_decoder

// >>> tb/fccd_host_model.sv
// Purpose: host side, sends 64-byte reports
// Assumes: caller fills rpt, calls send at a posedge
// Notes:   idle byte lines show the inverse of the last byte
`timescale 1ns/1ns
module fccd_host_model
(
   input  wire       i_clk_sys,
   input  wire       i_ce,
   output reg        o_valid,
   output reg  [7:0] o_byte
);
   reg [7:0] rpt [0:63];
   integer   i;
   integer   k;
   initial
   begin
      o_valid = 1'b0;
      o_byte = 8'h00;
   end
   ////////////////////////////////
   // a byte stands until an enabled edge takes it; gap models a slow host
   task send(input integer gap);
      for (i = 0; i < 64; i = i + 1)
      begin
         o_valid <= 1'b1;
         o_byte <= rpt[i];
         @(posedge i_clk_sys);
         while (i_ce !== 1'b1)
            @(posedge i_clk_sys);
         for (k = 0; k < gap; k = k + 1)
         begin
            o_valid <= 1'b0;
            o_byte <= ~rpt[i];
            @(posedge i_clk_sys);
         end
      end
      o_valid <= 1'b0;
      o_byte <= ~rpt[63];
   endtask
endmodule // fccd_host_model

// >>> tb/fccd_decoder_assertions.sv
// Purpose: port checks for the decoder
// Assumes: i_ce high around pin edges
// Notes:   bound at the foot
`timescale 1ns/1ns
module fccd_decoder_assertions
(
   input wire        i_clk_sys,
   input wire        i_rst,
   input wire        i_ce,
   input wire        i_int_pin,
   input wire        o_int_flag,
   input wire        o_resp_valid,
   input wire        o_commit,
   input wire [7:0]  o_resp_code,
   input wire [7:0]  o_nv_intcfg,
   input wire [15:0] o_nv_vid,
   input wire [14:0] o_nv_pins,
   input wire [1:0]  o_adc_ref_level,
   input wire [2:0]  o_pin_func
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   reg [1:0] up_reg;
   ////////////////////////////////
   // enabled edges since reset, live outputs settle by the second
   always @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
         up_reg <= 2'h0;
      else if (i_ce && up_reg != 2'h3)
         up_reg <= up_reg + 2'h1;
   property p_ok; o_commit |-> o_resp_valid && o_resp_code == 8'h00; endproperty
   a_ok: assert property (p_ok) else $error("commit without ok");
   property p_pulse; o_resp_valid && i_ce |=> !o_resp_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("response too long");
   property p_unsup; o_resp_code == 8'h01 |-> !o_commit; endproperty
   a_unsup: assert property (p_unsup) else $error("unsupported committed");
   property p_dc; (o_nv_intcfg & 8'h83) == 8'h00; endproperty
   a_dc: assert property (p_dc) else $error("spare bits stored");
   property p_hold; !o_commit |-> $stable(o_nv_vid) && $stable(o_nv_pins); endproperty
   a_hold: assert property (p_hold) else $error("image moved");
   property p_live; up_reg == 2'h3 |-> $stable({o_pin_func, o_adc_ref_level}); endproperty
   a_live: assert property (p_live) else $error("live moved");
   property p_neg; o_nv_intcfg[6] && $fell(i_int_pin) ##0 i_ce[*3] |-> ##[0:1] o_int_flag; endproperty
   a_neg: assert property (p_neg) else $error("fall missed");
   property p_pos; o_nv_intcfg[5] && $rose(i_int_pin) ##0 i_ce[*3] |-> ##[0:1] o_int_flag; endproperty
   a_pos: assert property (p_pos) else $error("rise missed");
   c_commit: cover property (o_commit);
   c_unsup: cover property (o_resp_valid && o_resp_code == 8'h01);
   c_flag: cover property ($rose(o_int_flag));
endmodule // fccd_decoder_assertions
bind fccd_decoder fccd_decoder_assertions chk (.i_clk_sys, .i_rst, .i_ce, .i_int_pin, .o_int_flag,
   .o_resp_valid, .o_commit, .o_resp_code, .o_nv_intcfg, .o_nv_vid, .o_nv_pins, .o_adc_ref_level, .o_pin_func);

// >>> tb/test_flash_config_command_decoder.sv
// Purpose: report-level tests of the decoder
// Assumes: 50 ns clock, host model drives bytes
// Notes:   spare bytes are sent as ff
`timescale 1ns/1ns
module test_flash_config_command_decoder;
   reg         i_clk_sys = 1'b0;
   reg         i_rst = 1'b1;
   reg         i_ce = 1'b1;
   reg         i_int_pin = 1'b0;
   reg         i_int_clear = 1'b0;
   reg         stall = 1'b1;
   reg  [14:0] exp_pins;
   wire        i_byte_valid, o_int_flag, o_resp_valid, o_commit, o_adc_ref_internal;
   wire [7:0]  i_byte, o_resp_code, o_nv_intcfg, o_nv_power, o_nv_current;
   wire [15:0] o_nv_vid, o_nv_pid;
   wire [63:0] o_nv_password;
   wire [14:0] o_nv_pins;
   wire [2:0]  o_pin_func, o_pin_dir_in, o_pin_level;
   wire [1:0]  o_adc_ref_level;
   integer     failures = 0, tests_run = 0, cyc = 0, n_resp = 0, n_com = 0, c, r, p;
   fccd_host_model host (.i_clk_sys, .i_ce, .o_valid(i_byte_valid), .o_byte(i_byte));
   fccd_decoder dut (.i_clk_sys, .i_rst, .i_ce, .i_byte_valid, .i_byte, .i_int_pin, .i_int_clear,
      .o_int_flag, .o_resp_valid, .o_resp_code, .o_commit, .o_nv_intcfg, .o_nv_vid, .o_nv_pid,
      .o_nv_power, .o_nv_current, .o_nv_password, .o_nv_pins, .o_adc_ref_level,
      .o_adc_ref_internal, .o_pin_func, .o_pin_dir_in, .o_pin_level);
   always #25 i_clk_sys = ~i_clk_sys;
   ////////////////////////////////
   // pulses counted only on advancing edges, since a frozen pulse lingers
   always @(posedge i_clk_sys)
   begin
      cyc <= cyc + 1;
      i_ce <= !(stall && cyc % 7 == 3);
      if (o_resp_valid === 1'b1 && i_ce)
         n_resp <= n_resp + 1;
      if (o_commit === 1'b1 && i_ce)
         n_com <= n_com + 1;
      if (cyc == 20000)
      begin
         failures = failures + 1;
         close_out;
      end
   end
   task close_out;
      begin
         if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task chk(input string nm, input [63:0] e, input [63:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e)
         begin
            failures = failures + 1;
            $display("MISMATCH %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task prep(input [7:0] sub);
      begin
         for (p = 0; p < 64; p = p + 1)
            host.rpt[p] = 8'hff;
         host.rpt[0] = 8'hb1;
         host.rpt[1] = sub;
      end
   endtask
   task go(input integer gap, input integer er, input integer ec, input [7:0] code);
      integer r0;
      integer c0;
      begin
         r0 = n_resp;
         c0 = n_com;
         host.send(gap);
         repeat (3) @(posedge i_clk_sys);
         chk("responses", er, n_resp - r0);
         chk("commits", ec, n_com - c0);
         if (er > 0)
            chk("code", code, o_resp_code);
      end
   endtask
   task pin_to(input v, input e);
      begin
         i_int_clear <= 1'b1;
         @(posedge i_clk_sys);
         i_int_clear <= 1'b0;
         i_int_pin <= v;
         repeat (4) @(posedge i_clk_sys);
         chk("int flag", e, o_int_flag);
      end
   endtask
   ////////////////////////////////
   initial
   begin
      repeat (12) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      prep(8'h00);
      for (p = 5; p < 20; p = p + 1)
         host.rpt[p] = 8'h30 + p;
      host.rpt[5] = 8'hff;
      go(1, 1, 1, 8'h00);
      stall = 1'b0;
      chk("intcfg", 8'h7c, o_nv_intcfg);
      chk("vid", 16'h3736, o_nv_vid);
      chk("pid", 16'h3938, o_nv_pid);
      chk("power", 8'h3a, o_nv_power);
      chk("current", 8'h3b, o_nv_current);
      chk("password", 64'h434241403f3e3d3c, o_nv_password);
      // live reference keeps the reset image until the next reset
      chk("ref level", 2'h0, o_adc_ref_level);
      chk("ref source", 1'b0, o_adc_ref_internal);
      pin_to(1, 1);
      pin_to(0, 1);
      for (r = 0; r < 2; r = r + 1)
      begin
         prep(8'h00);
         host.rpt[5] = r ? 8'h24 : 8'h48;
         go(0, 1, 1, 8'h00);
         chk("intcfg", r ? 8'h24 : 8'h48, o_nv_intcfg);
         pin_to(1, r);
         pin_to(0, !r);
      end
      for (c = 0; c < 8; c = c + 1)
      begin
         prep(8'h01);
         for (p = 0; p < 3; p = p + 1)
         begin
            host.rpt[2 + p] = {3'h5, c[0], c[1], c[2:0]};
            exp_pins[5 * p + 3 +: 2] = {c[0], c[1]};
            if (c <= (p == 0 ? 2 : p == 1 ? 4 : 3))
               exp_pins[5 * p +: 3] = c[2:0];
         end
         go(0, 1, 1, 8'h00);
         chk("pins", exp_pins, o_nv_pins);
      end
      // live pins keep the reset image: general-purpose inputs driving low
      chk("pin func", 3'h7, o_pin_func);
      chk("pin dir", 3'h7, o_pin_dir_in);
      chk("pin level", 3'h0, o_pin_level);
      for (c = 2; c < 7; c = c + 1)
      begin
         prep(c[7:0]);
         go(0, 1, 0, c > 4 ? 8'h01 : 8'h00);
      end
      prep(8'h01);
      host.rpt[0] = 8'hb0;
      go(0, 0, 0, 8'h00);
      chk("pins", exp_pins, o_nv_pins);
      close_out;
   end
endmodule // test_flash_config_command_decoder
